// *** design/bbspi_pkg.sv ***
// Shared constants and types of the bit-bang serial shifter.
package bbspi_pkg;

  // ---------------------------------------------------------------
  // Data path and timing
  // ---------------------------------------------------------------
  localparam int unsigned BBSPI_DATA_W     = 8;
  localparam int unsigned BBSPI_CNT_W      = 4;
  localparam logic [3:0]  BBSPI_FULL_COUNT = 4'h8;
  localparam logic [7:0]  BBSPI_TOP_BIT_WEIGHT = 8'h80;
  localparam int unsigned BBSPI_CLK_HZ     = 10_000_000;
  localparam int unsigned BBSPI_PULSE_US   = 10;
  localparam int unsigned BBSPI_TIMER_W    = 16;
  localparam int unsigned BBSPI_FIFO_DEPTH = 16;
  localparam int unsigned BBSPI_CMD_W      = 16;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned BBSPI_AXI_AW  = 8;
  localparam logic [7:0]  BBSPI_OFS_CMD    = 8'h00;
  localparam logic [7:0]  BBSPI_OFS_RXDATA = 8'h04;
  localparam logic [7:0]  BBSPI_OFS_STATUS = 8'h08;
  localparam logic [1:0]  BBSPI_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BBSPI_RESP_SLVERR = 2'h2;

  // Command word fields.
  localparam int unsigned BBSPI_CMD_DATA_LSB = 0;
  localparam int unsigned BBSPI_CMD_BITS_LSB = 8;
  localparam int unsigned BBSPI_CMD_MODE_LSB = 12;
  localparam int unsigned BBSPI_CMD_RX_BIT   = 15;

  // Status bits.
  localparam int unsigned BBSPI_STAT_BUSY     = 0;
  localparam int unsigned BBSPI_STAT_RX_VALID = 1;
  localparam int unsigned BBSPI_STAT_FULL     = 2;
  localparam int unsigned BBSPI_STAT_EMPTY    = 3;

  // ---------------------------------------------------------------
  // Mode codes and their bit meanings
  // ---------------------------------------------------------------
  localparam int unsigned BBSPI_RX_LSB_BIT    = 0;
  localparam int unsigned BBSPI_RX_LATE_BIT   = 1;
  localparam int unsigned BBSPI_IDLE_HIGH_BIT = 2;
  localparam int unsigned BBSPI_TX_MSB_BIT    = 0;
  localparam logic [2:0] msb_early_sample_low_idle  = 3'h0;
  localparam logic [2:0] lsb_early_sample_low_idle  = 3'h1;
  localparam logic [2:0] msb_late_sample_low_idle   = 3'h2;
  localparam logic [2:0] lsb_late_sample_low_idle   = 3'h3;
  localparam logic [2:0] msb_early_sample_high_idle = 3'h4;
  localparam logic [2:0] lsb_early_sample_high_idle = 3'h5;
  localparam logic [2:0] msb_late_sample_high_idle  = 3'h6;
  localparam logic [2:0] lsb_late_sample_high_idle  = 3'h7;
  localparam logic [2:0] lsb_out_low_idle  = 3'h0;
  localparam logic [2:0] msb_out_low_idle  = 3'h1;
  localparam logic [2:0] lsb_out_high_idle = 3'h4;
  localparam logic [2:0] msb_out_high_idle = 3'h5;

  // Phases of one bit.
  typedef enum logic [1:0] {
    BBSPI_IDLE,
    BBSPI_SETUP,
    BBSPI_PULSE,
    BBSPI_HOLD
  } bbspi_phase_t;

endpackage : bbspi_pkg

// *** design/bbspi_shifter.sv ***
// Bit-bang serial shifter with command FIFO and AXI4-Lite register slave.
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Command FIFO
// ---------------------------------------------------------------
module bbspi_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // Filling side.
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side.
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } bbspi_fifo_state_t;

  bbspi_fifo_state_t fifo_reg;
  bbspi_fifo_state_t fifo_next;
  logic              push;
  logic              pop;

  // Full and empty come straight from the stored count.
  assign o_in_ready  = (fifo_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (fifo_reg.count != '0);
  assign o_out_data  = fifo_reg.mem[fifo_reg.rd_ptr];

  // Pointer and count update for one push and one pop per cycle.
  always_comb begin
    fifo_next = fifo_reg;
    push      = i_in_valid && o_in_ready;
    pop       = i_out_ready && o_out_valid;
    if (push) begin
      fifo_next.mem[fifo_reg.wr_ptr] = i_in_data;
      if (fifo_reg.wr_ptr == AW'(DEPTH - 1)) begin
        fifo_next.wr_ptr = '0;
      end else begin
        fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
      end
    end
    if (pop) begin
      if (fifo_reg.rd_ptr == AW'(DEPTH - 1)) begin
        fifo_next.rd_ptr = '0;
      end else begin
        fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
      end
    end
    if (push && !pop) begin
      fifo_next.count = fifo_reg.count + 1'b1;
    end else if (pop && !push) begin
      fifo_next.count = fifo_reg.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

endmodule : bbspi_fifo

// ---------------------------------------------------------------
// Shifter top level
// ---------------------------------------------------------------
module bbspi_shifter
  import bbspi_pkg::*;
#(
  parameter int unsigned CLK_HZ     = BBSPI_CLK_HZ,
  parameter int unsigned FIFO_DEPTH = BBSPI_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_reset,
  // AXI4-Lite write address and data.
  input  wire logic                    i_s_axi_awvalid,
  output logic                         o_s_axi_awready,
  input  wire logic [BBSPI_AXI_AW-1:0] i_s_axi_awaddr,
  input  wire logic                    i_s_axi_wvalid,
  output logic                         o_s_axi_wready,
  input  wire logic [31:0]             i_s_axi_wdata,
  input  wire logic [3:0]              i_s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                         o_s_axi_bvalid,
  input  wire logic                    i_s_axi_bready,
  output logic [1:0]                   o_s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic                    i_s_axi_arvalid,
  output logic                         o_s_axi_arready,
  input  wire logic [BBSPI_AXI_AW-1:0] i_s_axi_araddr,
  output logic                         o_s_axi_rvalid,
  input  wire logic                    i_s_axi_rready,
  output logic [31:0]                  o_s_axi_rdata,
  output logic [1:0]                   o_s_axi_rresp,
  // Serial pins.
  output logic                         o_sclk,
  input  wire logic                    i_sdata,
  output logic                         o_sdata,
  output logic                         o_sdata_oe
);

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Pulse length in cycles follows the clock rate, rounded up.
  localparam longint unsigned PULSE_CYC =
    (longint'(BBSPI_PULSE_US) * longint'(CLK_HZ) + 64'd999_999) / 64'd1_000_000;
  localparam logic [BBSPI_TIMER_W-1:0] TIMER_LOAD =
    (PULSE_CYC > 1) ? BBSPI_TIMER_W'(PULSE_CYC - 1) : '0;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                     awready;
    logic [BBSPI_AXI_AW-1:0]  aw_addr;
    logic                     wready;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    bbspi_phase_t             phase;
    logic [BBSPI_TIMER_W-1:0] timer;
    logic [BBSPI_CNT_W-1:0]   bits_left;
    logic                     is_rx;
    logic [2:0]               mode;
    logic [BBSPI_DATA_W-1:0]  shreg;
    logic                     sclk;
    logic                     sdata;
    logic                     sdata_oe;
    logic [BBSPI_DATA_W-1:0]  rx_data;
    logic                     rx_valid;
    logic [1:0]               sync;
  } bbspi_state_t;

  bbspi_state_t               st_reg;
  bbspi_state_t               st_next;
  logic                       fifo_push;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [BBSPI_CMD_W-1:0]     fifo_out_data;
  logic                       fifo_pop_ready;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Picks the next outgoing bit for the given transmit mode.
  function automatic logic tx_bit(input logic [BBSPI_DATA_W-1:0] v, input logic [2:0] m);
    if (m[BBSPI_TX_MSB_BIT]) begin
      tx_bit = |(v & BBSPI_TOP_BIT_WEIGHT);
    end else begin
      tx_bit = v[0];
    end
  endfunction : tx_bit

  // Moves one sampled bit into the receive register.
  function automatic logic [BBSPI_DATA_W-1:0] rx_shift(input logic [BBSPI_DATA_W-1:0] v,
                                                       input logic [2:0] m, input logic b);
    if (m[BBSPI_RX_LSB_BIT]) begin
      rx_shift = {b, v[BBSPI_DATA_W-1:1]};
    end else begin
      rx_shift = {v[BBSPI_DATA_W-2:0], b};
    end
  endfunction : rx_shift

  // Count of zero or above eight means a full byte.
  function automatic logic [BBSPI_CNT_W-1:0] bit_count(input logic [BBSPI_CNT_W-1:0] c);
    if (c == '0 || c > BBSPI_FULL_COUNT) begin
      bit_count = BBSPI_FULL_COUNT;
    end else begin
      bit_count = c;
    end
  endfunction : bit_count

  // ---------------------------------------------------------------
  // Command FIFO
  // ---------------------------------------------------------------
  // The engine drains one command whenever it is idle.
  assign fifo_pop_ready = (st_reg.phase == BBSPI_IDLE);

  bbspi_fifo #(
    .WIDTH (BBSPI_CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (fifo_push),
    .i_in_data   ({st_reg.w_strb[1] ? st_reg.w_data[15:8] : 8'h00,
                   st_reg.w_strb[0] ? st_reg.w_data[7:0] : 8'h00}),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_pop_ready)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Bus slave, shift engine and status flags in one pass.
  always_comb begin
    logic                    rd_clear;
    logic                    rx_set;
    logic                    early;
    logic                    done;
    logic [BBSPI_DATA_W-1:0] sh;
    logic [2:0]              cmd_mode;
    rd_clear  = 1'b0;
    rx_set    = 1'b0;
    early     = 1'b0;
    done      = 1'b0;
    sh        = '0;
    cmd_mode  = '0;
    st_next   = st_reg;
    fifo_push = 1'b0;

    // Synchroniser for the incoming data line.
    st_next.sync = {st_reg.sync[0], i_sdata};

    // Write address and data are captured independently.
    if (st_reg.awready && i_s_axi_awvalid) begin
      st_next.awready = 1'b0;
      st_next.aw_addr = i_s_axi_awaddr;
    end
    if (st_reg.wready && i_s_axi_wvalid) begin
      st_next.wready = 1'b0;
      st_next.w_data = i_s_axi_wdata;
      st_next.w_strb = i_s_axi_wstrb;
    end

    // A full FIFO holds the write until a slot frees up.
    if (!st_reg.awready && !st_reg.wready && !st_reg.bvalid) begin
      if (st_reg.aw_addr[7:2] == BBSPI_OFS_CMD[7:2]) begin
        if (fifo_in_ready) begin
          fifo_push       = 1'b1;
          st_next.bvalid  = 1'b1;
          st_next.bresp   = BBSPI_RESP_OKAY;
          st_next.awready = 1'b1;
          st_next.wready  = 1'b1;
        end
      end else begin
        st_next.bvalid  = 1'b1;
        st_next.awready = 1'b1;
        st_next.wready  = 1'b1;
        if (st_reg.aw_addr[7:2] == BBSPI_OFS_RXDATA[7:2] ||
            st_reg.aw_addr[7:2] == BBSPI_OFS_STATUS[7:2]) begin
          st_next.bresp = BBSPI_RESP_OKAY;
        end else begin
          st_next.bresp = BBSPI_RESP_SLVERR;
        end
      end
    end
    if (st_reg.bvalid && i_s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read decode; reading the received byte clears its flag.
    if (st_reg.arready && i_s_axi_arvalid) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = BBSPI_RESP_OKAY;
      st_next.rdata   = '0;
      if (i_s_axi_araddr[7:2] == BBSPI_OFS_RXDATA[7:2]) begin
        st_next.rdata = {24'h000000, st_reg.rx_data};
        rd_clear      = 1'b1;
      end else if (i_s_axi_araddr[7:2] == BBSPI_OFS_STATUS[7:2]) begin
        st_next.rdata[BBSPI_STAT_BUSY]     = (st_reg.phase != BBSPI_IDLE);
        st_next.rdata[BBSPI_STAT_RX_VALID] = st_reg.rx_valid;
        st_next.rdata[BBSPI_STAT_FULL]     = !fifo_in_ready;
        st_next.rdata[BBSPI_STAT_EMPTY]    = !fifo_out_valid;
      end else if (i_s_axi_araddr[7:2] != BBSPI_OFS_CMD[7:2]) begin
        st_next.rresp = BBSPI_RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && i_s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end

    // Shift engine: setup, pulse and hold, each one pulse long.
    early = !st_reg.mode[BBSPI_RX_LATE_BIT];
    unique case (st_reg.phase)
      BBSPI_IDLE: begin
        if (fifo_out_valid) begin
          cmd_mode          = fifo_out_data[BBSPI_CMD_MODE_LSB +: 3];
          st_next.is_rx     = fifo_out_data[BBSPI_CMD_RX_BIT];
          st_next.mode      = cmd_mode;
          st_next.bits_left = bit_count(fifo_out_data[BBSPI_CMD_BITS_LSB +: BBSPI_CNT_W]);
          st_next.sclk      = cmd_mode[BBSPI_IDLE_HIGH_BIT];
          st_next.timer     = TIMER_LOAD;
          st_next.phase     = BBSPI_SETUP;
          if (fifo_out_data[BBSPI_CMD_RX_BIT]) begin
            st_next.shreg    = '0;
            st_next.sdata    = 1'b0;
            st_next.sdata_oe = 1'b0;
          end else begin
            st_next.shreg    = fifo_out_data[BBSPI_CMD_DATA_LSB +: BBSPI_DATA_W];
            st_next.sdata    = tx_bit(fifo_out_data[BBSPI_CMD_DATA_LSB +: BBSPI_DATA_W], cmd_mode);
            st_next.sdata_oe = 1'b1;
          end
        end
      end
      BBSPI_SETUP: begin
        if (st_reg.timer != '0) begin
          st_next.timer = st_reg.timer - 1'b1;
        end else begin
          if (st_reg.is_rx && early) begin
            st_next.shreg = rx_shift(st_reg.shreg, st_reg.mode, st_reg.sync[1]);
          end
          st_next.sclk  = !st_reg.mode[BBSPI_IDLE_HIGH_BIT];
          st_next.timer = TIMER_LOAD;
          st_next.phase = BBSPI_PULSE;
        end
      end
      BBSPI_PULSE: begin
        if (st_reg.timer != '0) begin
          st_next.timer = st_reg.timer - 1'b1;
        end else begin
          st_next.sclk  = st_reg.mode[BBSPI_IDLE_HIGH_BIT];
          st_next.timer = TIMER_LOAD;
          st_next.phase = BBSPI_HOLD;
        end
      end
      BBSPI_HOLD: begin
        if (st_reg.timer != '0) begin
          st_next.timer = st_reg.timer - 1'b1;
        end else begin
          done = (st_reg.bits_left == 4'h1);
          if (st_reg.is_rx) begin
            sh = early ? st_reg.shreg : rx_shift(st_reg.shreg, st_reg.mode, st_reg.sync[1]);
          end else if (st_reg.mode[BBSPI_TX_MSB_BIT]) begin
            sh = {st_reg.shreg[BBSPI_DATA_W-2:0], 1'b0};
          end else begin
            sh = {1'b0, st_reg.shreg[BBSPI_DATA_W-1:1]};
          end
          st_next.shreg     = sh;
          st_next.bits_left = st_reg.bits_left - 1'b1;
          st_next.timer     = TIMER_LOAD;
          if (done) begin
            st_next.phase    = BBSPI_IDLE;
            st_next.sdata    = 1'b0;
            st_next.sdata_oe = 1'b1;
            if (st_reg.is_rx) begin
              st_next.rx_data = sh;
              rx_set          = 1'b1;
            end
          end else begin
            st_next.phase = BBSPI_SETUP;
            if (!st_reg.is_rx) begin
              st_next.sdata = tx_bit(sh, st_reg.mode);
            end
          end
        end
      end
    endcase

    // A new byte wins over a clear in the same cycle.
    st_next.rx_valid = rx_set || (st_reg.rx_valid && !rd_clear);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset leaves both serial lines low and the bus ready.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg          <= '0;
      st_reg.awready  <= 1'b1;
      st_reg.wready   <= 1'b1;
      st_reg.arready  <= 1'b1;
      st_reg.sdata_oe <= 1'b1;
      st_reg.phase    <= BBSPI_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a stored bit of the state.
  assign o_s_axi_awready = st_reg.awready;
  assign o_s_axi_wready  = st_reg.wready;
  assign o_s_axi_bvalid  = st_reg.bvalid;
  assign o_s_axi_bresp   = st_reg.bresp;
  assign o_s_axi_arready = st_reg.arready;
  assign o_s_axi_rvalid  = st_reg.rvalid;
  assign o_s_axi_rdata   = st_reg.rdata;
  assign o_s_axi_rresp   = st_reg.rresp;
  assign o_sclk          = st_reg.sclk;
  assign o_sdata         = st_reg.sdata;
  assign o_sdata_oe      = st_reg.sdata_oe;

endmodule : bbspi_shifter

// *** dv/bbspi_shifter_sva.sv ***
// Concurrent checks on the shifter pins and register bus.
`timescale 1ns/10ps
module bbspi_shifter_sva
  import bbspi_pkg::*;
(
  // Clock and reset.
  input wire logic                    i_ref_clk,
  input wire logic                    i_reset,
  // Register bus.
  input wire logic                    i_s_axi_awvalid,
  input wire logic                    o_s_axi_awready,
  input wire logic                    o_s_axi_bvalid,
  input wire logic                    i_s_axi_bready,
  input wire logic [1:0]              o_s_axi_bresp,
  input wire logic                    i_s_axi_arvalid,
  input wire logic                    o_s_axi_arready,
  input wire logic [BBSPI_AXI_AW-1:0] i_s_axi_araddr,
  input wire logic                    o_s_axi_rvalid,
  input wire logic                    i_s_axi_rready,
  input wire logic [31:0]             o_s_axi_rdata,
  input wire logic [1:0]              o_s_axi_rresp,
  // Serial pins.
  input wire logic                    o_sclk,
  input wire logic                    o_sdata,
  input wire logic                    o_sdata_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] addr_reg;
  // Keeps the address of the read under way.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) addr_reg <= 8'h00;
    else if (i_s_axi_arvalid && o_s_axi_arready) addr_reg <= i_s_axi_araddr;
  end
  // A clock level, once reached, lasts at least eight more cycles.
  sequence s_clk_hold; $stable(o_sclk)[*8]; endsequence
  sequence s_data_hold; $stable(o_sdata)[*8]; endsequence
  a_pulse_width: assert property ($changed(o_sclk) |=> s_clk_hold)
    else $error("Serial clock phase too short.");
  a_data_steady: assert property ($changed(o_sclk) && o_sdata_oe |=> s_data_hold)
    else $error("Data moved near a clock edge.");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("Read not answered next cycle.");
  a_read_stand: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("Read data dropped early.");
  a_read_unmapped: assert property (o_s_axi_rvalid && addr_reg[7:2] > 6'h2 |->
    o_s_axi_rresp == BBSPI_RESP_SLVERR && o_s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused.");
  a_write_stand: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("Write response dropped early.");
  a_aw_block: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
    else $error("Second write address taken.");
  a_line_release: assert property ($rose(o_sdata_oe) |-> !o_sdata)
    else $error("Data not low after receive.");
endmodule : bbspi_shifter_sva

bind bbspi_shifter bbspi_shifter_sva chk_u (.i_ref_clk, .i_reset, .i_s_axi_awvalid, .o_s_axi_awready,
  .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
  .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .o_sclk, .o_sdata, .o_sdata_oe);

// *** dv/bbspi_peri.sv ***
// Serial peripheral model facing the shifter pins.
`timescale 1ns/10ps
module bbspi_peri (
  // Clock and control.
  input  wire logic        i_ref_clk,
  input  wire logic        i_clear,
  input  wire logic        i_idle_high,
  input  wire logic [15:0] i_pattern,
  // Serial pins.
  input  wire logic        i_sclk,
  input  wire logic        i_line,
  output logic             o_miso,
  // Observed traffic.
  output logic [15:0]      o_got,
  output logic [4:0]       o_edges
);
  logic       sclk_reg;
  logic       pulse_reg;
  logic [3:0] idx_reg;
  // Leading edge takes the line in, trailing edge moves to the next bit.
  always_ff @(posedge i_ref_clk) begin
    sclk_reg <= i_sclk;
    if (i_clear) begin
      o_got     <= 16'h0000;
      o_edges   <= 5'h00;
      idx_reg   <= 4'h0;
      pulse_reg <= 1'b0;
    end else if (i_sclk != sclk_reg && i_sclk != i_idle_high) begin
      o_got     <= {o_got[14:0], i_line};
      o_edges   <= o_edges + 5'h01;
      pulse_reg <= 1'b1;
    end else if (i_sclk != sclk_reg && pulse_reg) begin
      idx_reg   <= idx_reg + 4'h1;
      pulse_reg <= 1'b0;
    end
  end
  // The peripheral presents its stream on the line, first bit on top.
  assign o_miso = i_pattern[4'hF - idx_reg];
endmodule : bbspi_peri

// *** dv/bbspi_shifter_test.sv ***
// Register-level bench of the bit-bang serial shifter.
`timescale 1ns/10ps
module bbspi_shifter_test;
  import bbspi_pkg::*;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
  logic i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, d;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  logic o_sclk, o_sdata, o_sdata_oe, miso, line, clear = 1'b0, idle_high = 1'b0;
  logic [15:0] got;
  logic [4:0] edges;
  logic [2:0] m;
  logic [3:0] n;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  localparam logic [15:0] PAT = 16'hB38D;
  // The shared data line follows whichever side drives it.
  assign line = o_sdata_oe ? o_sdata : miso;
  always #50 i_ref_clk = ~i_ref_clk;
  bbspi_shifter dut_u (.i_ref_clk, .i_reset, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_awaddr, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid,
    .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid,
    .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .o_sclk, .i_sdata(line), .o_sdata, .o_sdata_oe);
  bbspi_peri peri_u (.i_ref_clk, .i_clear(clear), .i_idle_high(idle_high), .i_pattern(PAT), .i_sclk(o_sclk),
    .i_line(line), .o_miso(miso), .o_got(got), .o_edges(edges));
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // One register write; address and data are released as each is taken.
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
    @(posedge i_ref_clk);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_awaddr  <= a;
    i_s_axi_wvalid  <= 1'b1;
    i_s_axi_wdata   <= {16'h0000, v};
    i_s_axi_bready  <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid) break;
    end
    i_s_axi_bready <= 1'b0;
    chk(o_s_axi_bresp, er);
  endtask : axi_wr
  // One register read; data and response are taken at the answering edge.
  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr  <= a;
    i_s_axi_rready  <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid) break;
    end
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Clears the peripheral, queues one command and waits for the engine to finish.
  task automatic xfer(input logic [15:0] c);
    @(posedge i_ref_clk);
    idle_high <= c[14];
    clear     <= 1'b1;
    @(posedge i_ref_clk);
    clear <= 1'b0;
    axi_wr(BBSPI_OFS_CMD, c, BBSPI_RESP_OKAY);
    d = 32'h1;
    for (int k = 0; k < 4000 && d[3:0] !== 4'h8 && d[3:0] !== 4'hA; k++) axi_rd(BBSPI_OFS_STATUS);
    chk(d[0], 1'b0);
  endtask : xfer
  // Bits the peripheral should see, in wire order.
  function automatic logic [15:0] tx_exp(input logic [7:0] v, input int c, input logic msb);
    logic [15:0] e;
    e = 16'h0000;
    for (int k = 0; k < c; k++) e = {e[14:0], msb ? v[7 - k] : v[k]};
    return e;
  endfunction : tx_exp
  // Byte the shifter should assemble from the peripheral stream.
  function automatic logic [7:0] rx_exp(input int c, input logic lsb, input int off);
    logic [7:0] e;
    e = 8'h00;
    for (int k = 0; k < c; k++) e = lsb ? {PAT[15 - k - off], e[7:1]} : {e[6:0], PAT[15 - k - off]};
    return e;
  endfunction : rx_exp
  // Cuts a hung run short.
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    axi_rd(BBSPI_OFS_STATUS);
    chk({r, d}, {BBSPI_RESP_OKAY, 32'h8});
    chk({o_sclk, o_sdata, o_sdata_oe}, 3'h1);
    axi_wr(8'h0C, 16'h0000, BBSPI_RESP_SLVERR);
    axi_rd(8'h0C);
    chk({r, d}, {BBSPI_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 8; i++) begin
      m = (i[1] ? 3'h4 : 3'h0) | {2'h0, i[0]};
      n = i[2] ? 4'h4 : 4'h0;
      xfer({1'b0, m, n, 8'hA6});
      chk({edges, got, o_sclk}, {(i[2] ? 5'h4 : 5'h8), tx_exp(8'hA6, i[2] ? 4 : 8, m[0]), m[2]});
    end
    for (int i = 0; i < 16; i++) begin
      m = i[3:1];
      n = i[0] ? 4'h3 : 4'h0;
      xfer({1'b1, m, n, 8'h00});
      axi_rd(BBSPI_OFS_RXDATA);
      chk(d[7:0], rx_exp(i[0] ? 3 : 8, m[0], m[1]));
    end
    axi_rd(BBSPI_OFS_STATUS);
    chk(d[1], 1'b0);
    xfer(16'h1180);
    for (int i = 0; i < 17; i++) axi_wr(BBSPI_OFS_CMD, 16'h1180, BBSPI_RESP_OKAY);
    axi_rd(BBSPI_OFS_STATUS);
    chk(d[2], 1'b1);
    xfer(16'h1180);
    chk(edges, 5'h12);
    give_verdict();
  end
endmodule : bbspi_shifter_test
